// File: design/spi_access_pkg.sv
// Shared constants for the serial indirect register access engine.
// Assumes one system clock domain plus the host-driven serial clock domain.
package spi_access_pkg;

  // Global interface register offsets
  localparam logic [7:0] OFS_DATA_WINDOW = 8'hf0;
  localparam logic [7:0] OFS_STATUS      = 8'hfe;
  localparam logic [7:0] OFS_PAGE        = 8'hff;

  // Command bytes and command field layout
  localparam logic [7:0] CMD_NORMAL_READ  = 8'h60;
  localparam logic [7:0] CMD_NORMAL_WRITE = 8'h61;
  localparam logic [7:0] CMD_FAST_READ    = 8'h10;
  localparam int         CMD_DIR_BIT      = 0;
  localparam int         CMD_MODE_BIT     = 4;
  localparam int         CMD_SEL_LSB      = 1;
  localparam int         CMD_SEL_MSB      = 3;
  localparam int         CMD_OFS_LSB      = 5;
  localparam int         CMD_OFS_MSB      = 7;
  localparam logic [2:0] DEVICE_SELECT_CODE = 3'h0;
  localparam logic [2:0] NORMAL_PREFIX      = 3'h3;

  // Status byte bit positions
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_READ_ACK_FLAG_BIT = 5;
  localparam int FAST_ACK_BIT  = 0;

  // Reset values
  localparam logic [7:0]  PAGE_RESET   = 8'h00;
  localparam logic [63:0] WINDOW_RESET = 64'h0;

  // Byte framing
  localparam int         WINDOW_BYTES   = 8;
  localparam logic [2:0] LAST_BIT       = 3'h7;
  localparam logic [3:0] IDX_CMD        = 4'h0;
  localparam logic [3:0] IDX_ADDR       = 4'h1;
  localparam logic [3:0] IDX_DATA0      = 4'h2;
  localparam logic [3:0] IDX_MAX        = 4'hf;
  localparam logic [3:0] WLEN_MAX       = 4'h8;

  // Internal access engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRIT = 3'b100
  } access_state_t;

endpackage

// File: design/spi_link_engine.sv
// Serial-clock-domain half of the access engine: shifts bytes in and out.
// Assumes slave select frames every transfer; status, page and data words
// arriving from the system domain only change while the host is not reading them.
`timescale 1ns/1ps
module spi_link_engine
  import spi_access_pkg::*;
(
  input  wire logic        sck,
  input  wire logic        nrst,
  input  wire logic        ss_n,
  input  wire logic        mosi,
  input  wire logic        busy_lvl,
  input  wire logic        read_ack_flag_lvl,
  input  wire logic        fack_lvl,
  input  wire logic [7:0]  page_val,
  input  wire logic [63:0] window_val,
  input  wire logic [63:0] fast_val,
  output logic             miso,
  output logic             ev_toggle,
  output logic [7:0]       ev_byte,
  output logic [3:0]       ev_index
);

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [3:0] byte_cnt;
    logic [6:0] shift;
    logic [7:0] cmd;
    logic [7:0] addr;
    logic [1:0] busy_s;
    logic [1:0] read_ack_flag_s;
    logic [1:0] fack_s;
  } rx_t;

  typedef struct packed {
    logic [6:0] tx_shift;
    logic       miso;
    logic       fast_go;
    logic [2:0] data_idx;
  } tx_t;

  rx_t        rx_reg, rx_next;
  tx_t        tx_reg, tx_next;
  logic       link_rst_n;
  logic [7:0] rx_full;
  logic [7:0] status_byte;
  logic [7:0] tx_byte;
  logic       is_fast;
  logic       ev_tgl_reg;
  logic [7:0] ev_byte_reg;
  logic [3:0] ev_idx_reg;

  // Deselect clears the receive and transmit state, so no edge after a frame is needed
  assign link_rst_n  = nrst & ~ss_n;
  assign rx_full     = {rx_reg.shift, mosi};
  assign status_byte = {rx_reg.busy_s[1], 1'b0, rx_reg.read_ack_flag_s[1], 5'h00};
  assign is_fast     = rx_reg.cmd[CMD_MODE_BIT] & ~rx_reg.cmd[CMD_DIR_BIT] &
                       (rx_reg.cmd[CMD_SEL_MSB:CMD_SEL_LSB] == DEVICE_SELECT_CODE);

  // Rising edge: sample the host's bits, hand finished bytes to the system side
  always_comb begin
    rx_next           = rx_reg;
    rx_next.busy_s    = {rx_reg.busy_s[0], busy_lvl};
    rx_next.read_ack_flag_s    = {rx_reg.read_ack_flag_s[0], read_ack_flag_lvl};
    rx_next.fack_s    = {rx_reg.fack_s[0], fack_lvl};
    rx_next.bit_cnt   = rx_reg.bit_cnt + 3'h1;
    rx_next.shift     = rx_full[6:0];
    if (rx_reg.bit_cnt == LAST_BIT) begin
      if (rx_reg.byte_cnt == IDX_CMD) begin
        rx_next.cmd = rx_full;
      end
      if (rx_reg.byte_cnt == IDX_ADDR) begin
        rx_next.addr = rx_full;
      end
      if (rx_reg.byte_cnt != IDX_MAX) begin
        rx_next.byte_cnt = rx_reg.byte_cnt + 4'h1;
      end
    end
  end

  // Falling edge byte choice: window, status, page, or inline fast data
  always_comb begin
    tx_next = tx_reg;
    tx_byte = 8'h00;
    // Choice made only at a byte boundary, so indices step once per byte
    if (rx_reg.bit_cnt == 3'h0 && rx_reg.byte_cnt >= IDX_DATA0) begin
      if (is_fast) begin
        if (tx_reg.fast_go) begin
          tx_byte          = fast_val[8*tx_reg.data_idx +: 8];
          tx_next.data_idx = tx_reg.data_idx + 3'h1;
        end else begin
          tx_byte = {7'h00, rx_reg.fack_s[1]};
          if (rx_reg.fack_s[1]) begin
            tx_next.fast_go  = 1'b1;
            tx_next.data_idx = rx_reg.cmd[CMD_OFS_MSB:CMD_OFS_LSB];
          end
        end
      end else if (rx_reg.cmd == CMD_NORMAL_READ) begin
        case (rx_reg.addr)
          OFS_DATA_WINDOW: begin
            tx_byte          = window_val[8*tx_reg.data_idx +: 8];
            tx_next.data_idx = tx_reg.data_idx + 3'h1;
          end
          OFS_STATUS: tx_byte = status_byte;
          OFS_PAGE:   tx_byte = page_val;
          default:    tx_byte = 8'h00;                            // Dummy read
        endcase
      end
    end
    // Data changes on the falling edge, MSB first
    if (rx_reg.bit_cnt == 3'h0) begin
      tx_next.miso     = tx_byte[7];
      tx_next.tx_shift = tx_byte[6:0];
    end else begin
      tx_next.miso     = tx_reg.tx_shift[6];
      tx_next.tx_shift = {tx_reg.tx_shift[5:0], 1'b0};
    end
  end

  always_ff @(posedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rx_reg <= '0;
    end else begin
      rx_reg <= rx_next;
    end
  end

  always_ff @(negedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_reg <= '0;
    end else begin
      tx_reg <= tx_next;
    end
  end

  // Event word is not reset by deselect, or the last byte of a frame is lost
  assign miso      = tx_reg.miso;
  assign ev_byte   = ev_byte_reg;
  assign ev_index  = ev_idx_reg;
  assign ev_toggle = ev_tgl_reg;

  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      ev_tgl_reg  <= 1'b0;
      ev_byte_reg <= 8'h00;
      ev_idx_reg  <= 4'h0;
    end else if (!ss_n && rx_reg.bit_cnt == LAST_BIT) begin
      ev_tgl_reg  <= ~ev_tgl_reg;
      ev_byte_reg <= rx_full;
      ev_idx_reg  <= rx_reg.byte_cnt;
    end
  end

endmodule

// File: design/spi_indirect_register_access.sv
// System-clock half of the serial indirect register access engine.
// Holds page, data window and status, and runs the internal register access.
// Assumes the internal register file answers each request with one ack pulse.
`timescale 1ns/1ps

// Summary of operation
// - Page register at FFh picks the internal page for later addresses.
// - Data window at F0h returns the fetched internal register contents.
// - Status bit 7 shows an internal access still in progress.
// - Status bit 5 sets once the window holds the requested contents.
// - Normal read, fast read and normal write only; no fast write.
// - Command 60h is a normal read, 61h a normal write.
// - Normal read of a register address starts an internal fetch; dummy byte.
// - Window read gives lowest byte first, each byte MSB first.
// - Fast read: status poll, page setup, then command 10h with address.
// - Fast read returns status and data inline on the output line.
// - Data follows right after the status byte carrying the acknowledge.
// - Command: bit 0 direction, bit 4 fast, bits 3:1 select 000.
// - Data changes on falling edge, sampled on rising, clock idles high.
module spi_indirect_register_access
  import spi_access_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ss_n,
  input  wire logic        sck,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe,
  output logic             int_req,
  output logic             int_wr,
  output logic [7:0]       int_page,
  output logic [7:0]       int_addr,
  output logic [63:0]      int_wdata,
  output logic [3:0]       int_wlen,
  input  wire logic        int_ack,
  input  wire logic [63:0] int_rdata
);

  typedef struct packed {
    access_state_t state;
    logic [7:0]    cmd;
    logic [7:0]    addr;
    logic [7:0]    page;
    logic [63:0]   window;
    logic [63:0]   fast_data;
    logic [63:0]   wbuf;
    logic [3:0]    wlen;
    logic          read_ack_flag;
    logic          fast_ack;
    logic          fast_req;
    logic [7:0]    req_addr;
    logic [3:0]    req_len;
    logic [2:0]    ev_sync;
    logic [1:0]    ss_sync;
    logic [2:0]    ss_hist;
  } core_t;

  core_t       core_reg, core_next;
  logic        link_toggle;
  logic [7:0]  link_byte;
  logic [3:0]  link_index;
  logic        byte_event;
  logic        frame_end;
  logic        busy;
  logic        cmd_ok;
  logic        is_fast_read;
  logic        addr_global;
  logic [7:0]  rx_byte;
  logic [2:0]  data_slot;

  // Serial-clock side; the event toggle, byte and index it passes are held until the next byte
  spi_link_engine u_link (
    .sck        (sck),
    .nrst       (nrst),
    .ss_n       (ss_n),
    .mosi       (mosi),
    .busy_lvl   (busy),
    .read_ack_flag_lvl   (core_reg.read_ack_flag),
    .fack_lvl   (core_reg.fast_ack),
    .page_val   (core_reg.page),
    .window_val (core_reg.window),
    .fast_val   (core_reg.fast_data),
    .miso       (miso),
    .ev_toggle  (link_toggle),
    .ev_byte    (link_byte),
    .ev_index   (link_index)
  );

  // Busy is derived from the engine state so it can never disagree with it
  assign busy = (core_reg.state != ST_IDLE);

  // Toggle crossing: stage 0 feeds only stage 1, edge found on stages 1 and 2
  assign byte_event = core_reg.ev_sync[1] ^ core_reg.ev_sync[2];
  // Select release, delayed so the frame's last byte event is handled first
  assign frame_end  = core_reg.ss_hist[1] & ~core_reg.ss_hist[2];

  // The byte and its index are stable for a full byte time after the toggle
  assign rx_byte   = link_byte;
  assign data_slot = 3'(link_index - IDX_DATA0);

  // Command decode on the stored command byte, address decode on the received byte
  assign cmd_ok       = (core_reg.cmd[CMD_SEL_MSB:CMD_SEL_LSB] == DEVICE_SELECT_CODE);
  assign is_fast_read = cmd_ok & core_reg.cmd[CMD_MODE_BIT] & ~core_reg.cmd[CMD_DIR_BIT];
  assign addr_global  = (rx_byte == OFS_DATA_WINDOW) | (rx_byte == OFS_STATUS) | (rx_byte == OFS_PAGE);

  // Next-state logic for the whole system-side engine
  always_comb begin
    core_next         = core_reg;
    core_next.ev_sync = {core_reg.ev_sync[1:0], link_toggle};
    core_next.ss_sync = {core_reg.ss_sync[0], ss_n};
    core_next.ss_hist = {core_reg.ss_hist[1:0], core_reg.ss_sync[1]};

    // Incoming bytes from the link
    if (byte_event) begin
      if (link_index == IDX_CMD) begin
        core_next.cmd  = rx_byte;
        core_next.wlen = 4'h0;
        // A stale acknowledge from the last fast read must not release old data
        if (rx_byte[CMD_MODE_BIT] && !rx_byte[CMD_DIR_BIT] &&
            rx_byte[CMD_SEL_MSB:CMD_SEL_LSB] == DEVICE_SELECT_CODE) begin
          core_next.fast_ack = 1'b0;
        end
      end else if (link_index == IDX_ADDR) begin
        core_next.addr = rx_byte;
        if (core_reg.cmd == CMD_NORMAL_READ && !addr_global && !busy) begin
          // Address byte of a normal read starts the internal fetch
          core_next.state    = ST_READ;
          core_next.req_addr = rx_byte;
          core_next.fast_req = 1'b0;
          core_next.read_ack_flag     = 1'b0;
        end else if (is_fast_read && !busy) begin
          // Fast read leaves status bit 5 and the window alone
          core_next.state    = ST_READ;
          core_next.req_addr = rx_byte;
          core_next.fast_req = 1'b1;
          core_next.fast_ack = 1'b0;
        end
      end else if (core_reg.cmd == CMD_NORMAL_WRITE) begin
        // Only the normal write opcode stores data; no fast write exists
        if (core_reg.addr == OFS_PAGE) begin
          if (link_index == IDX_DATA0) begin
            core_next.page = rx_byte;
          end
        end else if (core_reg.addr == OFS_DATA_WINDOW) begin
          if (link_index < IDX_DATA0 + WLEN_MAX) begin
            core_next.window[8*data_slot +: 8] = rx_byte;
          end
        end else if (core_reg.addr != OFS_STATUS) begin
          // Lowest byte first; bytes beyond the window width are dropped
          if (link_index < IDX_DATA0 + WLEN_MAX) begin
            core_next.wbuf[8*data_slot +: 8] = rx_byte;
            core_next.wlen = 4'(link_index - IDX_CMD - 4'h1);
          end
        end
      end
    end

    // End of a write frame hands the collected bytes to the internal side
    if (frame_end && core_reg.cmd == CMD_NORMAL_WRITE && !addr_is_global(core_reg.addr) &&
        core_reg.wlen != 4'h0 && !busy) begin
      core_next.state    = ST_WRIT;
      core_next.req_addr = core_reg.addr;
      core_next.req_len  = core_reg.wlen;
    end

    // Internal access engine
    case (core_reg.state)
      ST_IDLE: begin
        core_next.state = core_next.state;
      end
      ST_READ: begin
        if (int_ack) begin
          core_next.state = ST_IDLE;
          if (core_reg.fast_req) begin
            core_next.fast_data = int_rdata;
            core_next.fast_ack  = 1'b1;
          end else begin
            core_next.window = int_rdata;
            core_next.read_ack_flag   = 1'b1;
          end
        end
      end
      ST_WRIT: begin
        if (int_ack) begin
          core_next.state = ST_IDLE;
          core_next.wlen  = 4'h0;
        end
      end
      default: begin
        core_next.state = ST_IDLE;
      end
    endcase
  end

  // True for the three global interface offsets
  function automatic logic addr_is_global(input logic [7:0] a);
    addr_is_global = (a == OFS_DATA_WINDOW) | (a == OFS_STATUS) | (a == OFS_PAGE);
  endfunction

  // Single register stage for all system-side state
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      core_reg          <= '0;
      core_reg.state    <= ST_IDLE;
      core_reg.page     <= PAGE_RESET;
      core_reg.window   <= WINDOW_RESET;
      core_reg.ss_sync  <= 2'b11;
      core_reg.ss_hist  <= 3'b111;
    end else begin
      core_reg <= core_next;
    end
  end

  // Internal request port; address, length and direction held for the whole access, page and write data follow their registers
  assign int_req   = (core_reg.state == ST_READ) | (core_reg.state == ST_WRIT);
  assign int_wr    = (core_reg.state == ST_WRIT);
  assign int_page  = core_reg.page;
  assign int_addr  = core_reg.req_addr;
  assign int_wdata = core_reg.wbuf;
  assign int_wlen  = core_reg.req_len;

  // Output line is driven only while selected; released otherwise
  assign miso_oe = ~ss_n;

endmodule

// File: testbench/spi_access_props.sv
// Checker for the indirect access engine, bound to its top module.
// Assumes the internal register file acks each request with a one-cycle pulse.
`timescale 1ns/1ps
module spi_access_props
  import spi_access_pkg::*;
(
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       ss_n,
  input wire logic       sck,
  input wire logic       miso,
  input wire logic       miso_oe,
  input wire logic       int_req,
  input wire logic       int_wr,
  input wire logic [7:0] int_page,
  input wire logic [7:0] int_addr,
  input wire logic [3:0] int_wlen,
  input wire logic       int_ack
);
  logic [4:0] bit_cnt;

  // Rising edges seen in this frame, saturating past the header
  always_ff @(posedge sck or posedge ss_n) begin
    if (ss_n) begin
      bit_cnt <= 5'h00;
    end else if (bit_cnt != 5'h10) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  a_oe_follows_select: assert property (@(posedge mclk) disable iff (!nrst) miso_oe == !ss_n)
    else $error("output enable does not follow select");
  a_miso_quiet_idle: assert property (@(posedge mclk) disable iff (!nrst) ss_n |-> !miso)
    else $error("data out not low while deselected");
  a_header_quiet: assert property (@(posedge sck) disable iff (!nrst || ss_n) bit_cnt < 5'h10 |-> !miso)
    else $error("data out not zero during command and address");
  a_req_holds: assert property (@(posedge mclk) disable iff (!nrst) int_req && !int_ack |=> int_req)
    else $error("request dropped before ack");
  a_req_ends: assert property (@(posedge mclk) disable iff (!nrst) int_req && int_ack |=> !int_req)
    else $error("request not ended after ack");
  a_req_stable: assert property (@(posedge mclk) disable iff (!nrst)
    int_req && !int_ack |=> $stable(int_addr) && $stable(int_wr) && $stable(int_page))
    else $error("request fields changed while pending");
  a_wlen_range: assert property (@(posedge mclk) disable iff (!nrst)
    int_req && int_wr |-> int_wlen >= 4'h1 && int_wlen <= 4'h8)
    else $error("write length out of range");
  a_req_gap: assert property (@(posedge mclk) disable iff (!nrst) $fell(int_req) |-> !int_req [*2])
    else $error("new request right after completion");
endmodule

bind spi_indirect_register_access spi_access_props i_spi_access_props (
  .mclk(mclk), .nrst(nrst), .ss_n(ss_n), .sck(sck), .miso(miso), .miso_oe(miso_oe), .int_req(int_req),
  .int_wr(int_wr), .int_page(int_page), .int_addr(int_addr), .int_wlen(int_wlen), .int_ack(int_ack)
);

// File: testbench/spi_host.sv
// Behavioural serial host: frames command, address and data bytes.
// Serial clock period 32 ns, running only inside frames.
`timescale 1ns/1ps
module spi_host (
  output logic      ss_n,
  output logic      sck,
  output logic      mosi,
  input  wire logic miso
);
  // Idle: deselected, clock high
  initial begin
    ss_n = 1'b1;
    sck  = 1'b1;
    mosi = 1'b1;
  end

  // One byte, MSB first; drive on falling, sample on rising
  task automatic shift(input logic [7:0] o, output logic [7:0] i);
    for (int j = 7; j >= 0; j--) begin
      sck = 1'b0;
      mosi = o[j];
      #16;
      sck = 1'b1;
      i[j] = miso;
      #16;
    end
  endtask

  // Whole frame; fast mode skips status bytes until the ack bit
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] addr, input int nb,
                      input logic [63:0] wd, input logic fast, output logic [63:0] rd);
    logic [7:0] b;
    rd = '0;
    ss_n = 1'b0;
    #16;
    shift(cmd, b);
    shift(addr, b);
    if (fast) begin
      for (int k = 0; k < 64; k++) begin
        shift(8'h00, b);
        if (b[0]) break;
      end
    end
    for (int k = 0; k < nb; k++) begin
      shift(wd[8*k+:8], b);
      rd[8*k+:8] = b;
    end
    ss_n = 1'b1;
    mosi = ~mosi; // Released line shows no stale value
    #250;
  endtask
endmodule

// File: testbench/tb_top.sv
// Self-checking bench: serial host model plus an internal register file model.
// Frames are spaced 250 ns so status crossings settle before the next poll.
`timescale 1ns/1ps
module tb_top;
  import spi_access_pkg::*;
  localparam logic [63:0] RDATA = 64'h8877665544332211;
  logic        mclk, nrst, ss_n, sck, mosi, miso, miso_oe;
  logic        int_req, int_wr, int_ack, pend, seen_wr;
  logic [7:0]  int_page, int_addr, seen_addr, seen_page, cmd;
  logic [3:0]  int_wlen, seen_wlen;
  logic [63:0] int_wdata, int_rdata, rd, seen_wdata;
  int          n_fail, n_checks, ack_dly, n_req, cnt;

  spi_indirect_register_access i_spi_indirect_register_access (
    .mclk(mclk), .nrst(nrst), .ss_n(ss_n), .sck(sck), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .int_req(int_req), .int_wr(int_wr), .int_page(int_page), .int_addr(int_addr), .int_wdata(int_wdata),
    .int_wlen(int_wlen), .int_ack(int_ack), .int_rdata(int_rdata));
  spi_host i_spi_host (.ss_n(ss_n), .sck(sck), .mosi(mosi), .miso(miso));

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // Register file model: takes a request, raises ack ack_dly+1 cycles later
  always @(posedge mclk) begin
    if (int_req && !int_ack && !pend) begin
      pend <= 1'b1;
      cnt <= ack_dly;
      seen_wr <= int_wr;
      seen_addr <= int_addr;
      seen_page <= int_page;
      seen_wlen <= int_wlen;
      seen_wdata <= int_wdata;
      n_req <= n_req + 1;
      int_ack <= 1'b0;
    end else if (pend && cnt == 0) begin
      pend <= 1'b0;
      int_ack <= 1'b1;
    end else begin
      cnt <= cnt - 1;
      int_ack <= 1'b0;
    end
  end

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic xfer(input logic [7:0] c, input logic [7:0] a, input int nb, input logic [63:0] wd,
                      input logic fast);
    i_spi_host.xfer(c, a, nb, wd, fast, rd);
  endtask

  // Bounded wait until the internal access has finished
  task automatic wait_idle();
    for (int i = 0; i < 400 && (int_req || pend); i++) @(posedge mclk);
    repeat (2) @(posedge mclk);
    chk("request idle", 64'h0, {63'h0, int_req});
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog, several times the expected run
  initial begin
    #300000;
    n_fail++;
    close_out();
  end

  initial begin
    nrst = 1'b0;
    int_ack = 1'b0;
    int_rdata = RDATA;
    pend = 1'b0;
    cnt = 0;
    ack_dly = 120;
    n_req = 0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    xfer(CMD_NORMAL_READ, OFS_STATUS, 1, 64'h0, 1'b0);
    chk("status idle", 64'h00, rd);
    xfer(CMD_NORMAL_WRITE, OFS_PAGE, 1, 64'h10, 1'b0);
    xfer(CMD_NORMAL_READ, OFS_PAGE, 1, 64'h0, 1'b0);
    chk("page", 64'h10, rd);
    // Dummy read starts a slow fetch; status must show busy meanwhile
    xfer(CMD_NORMAL_READ, 8'h12, 1, 64'h0, 1'b0);
    chk("dummy byte", 64'h00, rd);
    xfer(CMD_NORMAL_READ, OFS_STATUS, 1, 64'h0, 1'b0);
    chk("status busy", 64'h80, rd);
    wait_idle();
    chk("fetch req", {8'h10, 8'h12, 1'b0}, {seen_page, seen_addr, seen_wr});
    xfer(CMD_NORMAL_READ, OFS_STATUS, 1, 64'h0, 1'b0);
    chk("status ack", 64'h20, rd);
    xfer(CMD_NORMAL_READ, OFS_DATA_WINDOW, 8, 64'h0, 1'b0);
    chk("window", RDATA, rd);
    // Normal write of three bytes, prompt answer
    ack_dly = 3;
    xfer(CMD_NORMAL_WRITE, 8'h34, 3, 64'hccbbaa, 1'b0);
    wait_idle();
    chk("write req", {1'b1, 8'h34, 4'h3, 24'hccbbaa}, {seen_wr, seen_addr, seen_wlen, seen_wdata[23:0]});
    chk("req count", 64'h2, 64'(n_req));
    // Refused: wrong select code, fast write, write to status
    xfer(CMD_NORMAL_WRITE | 8'h02, OFS_PAGE, 1, 64'h55, 1'b0);
    xfer(CMD_FAST_READ | 8'h01, 8'h12, 1, 64'h0, 1'b0);
    xfer(CMD_NORMAL_WRITE, OFS_STATUS, 1, 64'hff, 1'b0);
    wait_idle();
    chk("refused count", 64'h2, 64'(n_req));
    xfer(CMD_NORMAL_READ, OFS_PAGE, 1, 64'h0, 1'b0);
    chk("page kept", 64'h10, rd);
    // Fast reads: offset 0 prompt, offset 2 slow
    for (int o = 0; o < 3; o += 2) begin
      ack_dly = (o == 0) ? 2 : 60;
      int_rdata = (o == 0) ? RDATA : ~RDATA;
      cmd = {o[2:0], 5'h10};
      xfer(cmd, 8'h12, 8 - o, 64'h0, 1'b1);
      chk("fast data", ((o == 0) ? RDATA : ~RDATA) >> (8 * o), rd);
      wait_idle();
    end
    chk("fast count", 64'h4, 64'(n_req));
    xfer(CMD_NORMAL_READ, OFS_STATUS, 1, 64'h0, 1'b0);
    chk("status after fast", 64'h20, rd);
    close_out();
  end
endmodule
